//--- src/msf_pkg.sv
// Shared constants for the monitor stack frame block
package msf_pkg;
    localparam int unsigned MSF_DW       = 8;
    localparam int unsigned MSF_PCW      = 16;
    localparam int unsigned MSF_SPW      = 16;
    localparam int unsigned MSF_RAM_AW   = 8;
    // Frame offsets above the stack pointer left after entry
    localparam logic [2:0]  MSF_OFS_H    = 3'h1;
    localparam logic [2:0]  MSF_OFS_CCR  = 3'h2;
    localparam logic [2:0]  MSF_OFS_A    = 3'h3;
    localparam logic [2:0]  MSF_OFS_XL   = 3'h4;
    localparam logic [2:0]  MSF_OFS_PCH  = 3'h5;
    localparam logic [2:0]  MSF_OFS_PCL  = 3'h6;
    // Five bytes from interrupt stacking plus the index high byte
    localparam logic [2:0]  MSF_FRAME_N  = 3'h6;
    localparam logic [15:0] MSF_SP_RESET = 16'h00ff;
    localparam logic [15:0] MSF_SP_READ_ADJ = 16'h0001;

    typedef enum logic [3:0] {
        MSF_IDLE = 4'b0001,
        MSF_PUSH = 4'b0010,
        MSF_MON  = 4'b0100,
        MSF_POP  = 4'b1000
    } msf_state_t;
endpackage

//--- src/msf_stack_ram.sv
// Byte-wide stack memory with registered read port
`timescale 1ns/1ps
`default_nettype none
module msf_stack_ram #(
    parameter int unsigned AW = 8,
    parameter int unsigned DW = 8
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // Read-before-write: a read in the write cycle returns the old byte
    always_ff @(posedge clk) begin
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire

//--- src/msf_top.sv
// Monitor-mode stack frame save, host edit and restore engine
`timescale 1ns/1ps
`default_nettype none
module msf_top
    import msf_pkg::*;
#(
    parameter int unsigned RAM_AW = MSF_RAM_AW
) (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               enter_monitor,
    input  wire logic               run_cmd,
    input  wire logic               read_stack_pointer_cmd,
    input  wire logic               host_wr,
    input  wire logic               host_rd,
    input  wire logic [MSF_SPW-1:0] host_addr,
    input  wire logic [MSF_DW-1:0]  host_wdata,
    input  wire logic [MSF_PCW-1:0] core_pc,
    input  wire logic [MSF_DW-1:0]  core_a,
    input  wire logic [MSF_DW-1:0]  core_xl,
    input  wire logic [MSF_DW-1:0]  core_h,
    input  wire logic [MSF_DW-1:0]  core_ccr,
    input  wire logic [MSF_SPW-1:0] core_sp,
    output logic                    in_monitor_q,
    output logic                    busy_q,
    output logic      [MSF_SPW-1:0] sp_read_q,
    output logic                    sp_read_valid_q,
    output logic      [MSF_DW-1:0]  host_rdata_q,
    output logic                    host_rdata_valid_q,
    output logic                    resume_q,
    output logic      [MSF_PCW-1:0] resume_pc_q,
    output logic      [MSF_DW-1:0]  resume_a_q,
    output logic      [MSF_DW-1:0]  resume_xl_q,
    output logic      [MSF_DW-1:0]  resume_h_q,
    output logic      [MSF_DW-1:0]  resume_ccr_q,
    output logic      [MSF_SPW-1:0] resume_sp_q
);
    msf_state_t         state_q;
    logic [2:0]         step_q;
    logic [MSF_SPW-1:0] sp_q;
    logic [MSF_PCW-1:0] pc_cap_q;
    logic [MSF_DW-1:0]  a_cap_q;
    logic [MSF_DW-1:0]  xl_cap_q;
    logic [MSF_DW-1:0]  h_cap_q;
    logic [MSF_DW-1:0]  ccr_cap_q;
    logic               host_rd_pend_q;

    logic               ram_we;
    logic [RAM_AW-1:0]  ram_addr;
    logic [MSF_DW-1:0]  ram_wdata;
    logic [MSF_DW-1:0]  ram_rdata;

    // Interrupt stacking order, then the index high byte last
    function automatic logic [MSF_DW-1:0] push_byte(input logic [2:0] step);
        case (step)
            3'h0:    push_byte = pc_cap_q[7:0];
            3'h1:    push_byte = pc_cap_q[15:8];
            3'h2:    push_byte = xl_cap_q;
            3'h3:    push_byte = a_cap_q;
            3'h4:    push_byte = ccr_cap_q;
            default: push_byte = h_cap_q;
        endcase
    endfunction

    always_comb begin
        ram_we    = 1'b0;
        ram_addr  = host_addr[RAM_AW-1:0];
        ram_wdata = host_wdata;
        case (state_q)
            MSF_PUSH: begin
                // Post-decrement stack: write at SP, then SP moves down
                ram_we    = 1'b1;
                ram_addr  = sp_q[RAM_AW-1:0];
                ram_wdata = push_byte(step_q);
            end
            MSF_POP: begin
                ram_addr = RAM_AW'(sp_q + MSF_SPW'(step_q) + 16'h0001);
            end
            MSF_MON: begin
                ram_we = host_wr;
            end
            default: begin
                ram_we = 1'b0;
            end
        endcase
    end

    msf_stack_ram #(
        .AW (RAM_AW),
        .DW (MSF_DW)
    ) u_ram (
        .clk   (clk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    // Sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= MSF_IDLE;
            step_q  <= 3'h0;
        end else begin
            case (state_q)
                MSF_IDLE: begin
                    step_q <= 3'h0;
                    if (enter_monitor) begin
                        state_q <= MSF_PUSH;
                    end
                end
                MSF_PUSH: begin
                    if (step_q == MSF_FRAME_N - 3'h1) begin
                        step_q  <= 3'h0;
                        state_q <= MSF_MON;
                    end else begin
                        step_q <= step_q + 3'h1;
                    end
                end
                MSF_MON: begin
                    // Run is refused while a host read is still pending
                    if (run_cmd && !host_rd_pend_q) begin
                        step_q  <= 3'h0;
                        state_q <= MSF_POP;
                    end
                end
                MSF_POP: begin
                    if (step_q == MSF_FRAME_N) begin
                        step_q  <= 3'h0;
                        state_q <= MSF_IDLE;
                    end else begin
                        step_q <= step_q + 3'h1;
                    end
                end
                default: begin
                    state_q <= MSF_IDLE;
                    step_q  <= 3'h0;
                end
            endcase
        end
    end

    // Stack pointer tracks pushes and pops
    always_ff @(posedge clk) begin
        if (reset) begin
            sp_q <= MSF_SP_RESET;
        end else if (state_q == MSF_IDLE && enter_monitor) begin
            sp_q <= core_sp;
        end else if (state_q == MSF_PUSH) begin
            sp_q <= sp_q - 16'h0001;
        end else if (state_q == MSF_POP && step_q == MSF_FRAME_N) begin
            sp_q <= sp_q + MSF_SPW'(MSF_FRAME_N);
        end
    end

    // Core state is captured once so a moving core cannot tear the frame
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_cap_q  <= 16'h0000;
            a_cap_q   <= 8'h00;
            xl_cap_q  <= 8'h00;
            h_cap_q   <= 8'h00;
            ccr_cap_q <= 8'h00;
        end else if (state_q == MSF_IDLE && enter_monitor) begin
            pc_cap_q  <= core_pc;
            a_cap_q   <= core_a;
            xl_cap_q  <= core_xl;
            h_cap_q   <= core_h;
            ccr_cap_q <= core_ccr;
        end
    end

    // Restore: byte read at step k-1 arrives at step k, offset k
    always_ff @(posedge clk) begin
        if (reset) begin
            resume_pc_q  <= 16'h0000;
            resume_a_q   <= 8'h00;
            resume_xl_q  <= 8'h00;
            resume_h_q   <= 8'h00;
            resume_ccr_q <= 8'h00;
        end else if (state_q == MSF_POP) begin
            case (step_q)
                MSF_OFS_H:   resume_h_q          <= ram_rdata;
                MSF_OFS_CCR: resume_ccr_q        <= ram_rdata;
                MSF_OFS_A:   resume_a_q          <= ram_rdata;
                MSF_OFS_XL:  resume_xl_q         <= ram_rdata;
                MSF_OFS_PCH: resume_pc_q[15:8]   <= ram_rdata;
                MSF_OFS_PCL: resume_pc_q[7:0]    <= ram_rdata;
                default:     resume_h_q          <= resume_h_q;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            resume_q    <= 1'b0;
            resume_sp_q <= MSF_SP_RESET;
        end else begin
            resume_q <= (state_q == MSF_POP) && (step_q == MSF_FRAME_N);
            if (state_q == MSF_POP && step_q == MSF_FRAME_N) begin
                resume_sp_q <= sp_q + MSF_SPW'(MSF_FRAME_N);
            end
        end
    end

    // Host access and stack pointer read while parked in monitor mode
    always_ff @(posedge clk) begin
        if (reset) begin
            sp_read_q          <= 16'h0000;
            sp_read_valid_q    <= 1'b0;
            host_rd_pend_q     <= 1'b0;
            host_rdata_q       <= 8'h00;
            host_rdata_valid_q <= 1'b0;
        end else begin
            sp_read_valid_q <= (state_q == MSF_MON) && read_stack_pointer_cmd;
            if (state_q == MSF_MON && read_stack_pointer_cmd) begin
                sp_read_q <= sp_q + MSF_SP_READ_ADJ;
            end
            host_rd_pend_q     <= (state_q == MSF_MON) && host_rd && !host_wr && !run_cmd;
            host_rdata_valid_q <= host_rd_pend_q;
            if (host_rd_pend_q) begin
                host_rdata_q <= ram_rdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            in_monitor_q <= 1'b0;
            busy_q       <= 1'b0;
        end else begin
            in_monitor_q <= (state_q == MSF_MON && !(run_cmd && !host_rd_pend_q))
                            || (state_q == MSF_PUSH && step_q == MSF_FRAME_N - 3'h1);
            busy_q       <= (state_q == MSF_IDLE && enter_monitor)
                            || (state_q == MSF_PUSH && step_q != MSF_FRAME_N - 3'h1)
                            || (state_q == MSF_MON && run_cmd && !host_rd_pend_q)
                            || (state_q == MSF_POP && step_q != MSF_FRAME_N);
        end
    end
endmodule
`default_nettype wire

//--- bench/msf_checker.sv
// Port assertions for the monitor stack frame engine
`timescale 1ns/1ps
`default_nettype none
module msf_checker
    import msf_pkg::*;
(
    input wire logic               clk,
    input wire logic               reset,
    input wire logic               enter_monitor,
    input wire logic               run_cmd,
    input wire logic               read_stack_pointer_cmd,
    input wire logic               host_wr,
    input wire logic               host_rd,
    input wire logic [MSF_SPW-1:0] core_sp,
    input wire logic               in_monitor_q,
    input wire logic               busy_q,
    input wire logic [MSF_SPW-1:0] sp_read_q,
    input wire logic               sp_read_valid_q,
    input wire logic               host_rdata_valid_q,
    input wire logic               resume_q,
    input wire logic [MSF_SPW-1:0] resume_sp_q
);
    logic [15:0] sp0_q;
    logic        rdp_q;
    wire idle = !busy_q && !in_monitor_q;
    wire rd_ok = in_monitor_q && host_rd && !host_wr && !run_cmd;
    // A read in flight blocks the run, so the run is only counted when none is
    wire run_ok = in_monitor_q && run_cmd && !rdp_q;
    always_ff @(posedge clk) begin
        rdp_q <= reset ? 1'b0 : rd_ok;
    end
    always_ff @(posedge clk) begin
        if (reset) sp0_q <= '0;
        else if (idle && enter_monitor) sp0_q <= core_sp;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_entry_lat: assert property (idle && enter_monitor |-> ##7 in_monitor_q)
        else $error("monitor entry latency wrong");
    chk_entry_busy: assert property (idle && enter_monitor |=> busy_q [*6] ##1 !busy_q)
        else $error("save sequence length wrong");
    chk_sp_value: assert property (in_monitor_q && read_stack_pointer_cmd
        |=> sp_read_valid_q && sp_read_q == sp0_q - 16'h0005) else $error("sp read wrong");
    chk_sp_refuse: assert property (!in_monitor_q && read_stack_pointer_cmd
        |=> !sp_read_valid_q) else $error("sp read outside monitor");
    chk_rd_lat: assert property (rd_ok |-> ##2 host_rdata_valid_q)
        else $error("host read latency wrong");
    chk_run_seq: assert property (run_ok |=> !in_monitor_q && busy_q ##7 resume_q)
        else $error("restore sequence wrong");
    chk_resume_sp: assert property (resume_q |-> resume_sp_q == sp0_q)
        else $error("restored stack pointer wrong");
    chk_mon_holds: assert property (in_monitor_q && !run_ok |=> in_monitor_q)
        else $error("monitor state left early");
    chk_run_refuse: assert property (idle && run_cmd && !enter_monitor
        |=> !busy_q && !in_monitor_q) else $error("run taken outside monitor");
    cov_entry: cover property (idle && enter_monitor);
    cov_run_refused: cover property (in_monitor_q && run_cmd && rdp_q);
    cov_read: cover property (rd_ok);
    cov_run: cover property (run_ok);
endmodule
bind msf_top msf_checker u_chk (.clk(clk), .reset(reset), .enter_monitor(enter_monitor),
    .run_cmd(run_cmd), .read_stack_pointer_cmd(read_stack_pointer_cmd), .host_wr(host_wr),
    .host_rd(host_rd), .core_sp(core_sp), .in_monitor_q(in_monitor_q), .busy_q(busy_q),
    .sp_read_q(sp_read_q), .sp_read_valid_q(sp_read_valid_q), .resume_q(resume_q),
    .host_rdata_valid_q(host_rdata_valid_q), .resume_sp_q(resume_sp_q));
`default_nettype wire

//--- bench/msf_host.sv
// Host model issuing monitor commands and stack edits
`timescale 1ns/1ps
`default_nettype none
module msf_host (
    input  wire logic        clk,
    input  wire logic        rdv,
    output logic             run,
    output logic             rsp,
    output logic             wr,
    output logic             rd,
    output logic [15:0]      addr,
    output logic [7:0]       wdata
);
    initial {run, rsp, wr, rd, addr, wdata} = '0;
    // Released lines show the inverse so stale values never pass
    task automatic put(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic get(input logic [15:0] a, output bit ok);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        ok = 0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            ok = (rdv === 1'b1);
        end
    endtask
    task automatic cmd(input bit go);
        @(posedge clk);
        if (go) run <= 1'b1;
        else rsp <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        rsp <= 1'b0;
    endtask
    // Run one edge after a read: the read is still pending, so run is refused
    task automatic rd_run(input logic [15:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        run <= 1'b1;
        @(posedge clk);
        run <= 1'b0;
        addr <= ~a;
    endtask
endmodule
`default_nettype wire

//--- bench/msf_tb.sv
// Self-checking bench for the monitor stack frame engine
`timescale 1ns/1ps
`default_nettype none
module msf_tb;
    import msf_pkg::*;
    logic clk, reset, em, run, rsp, wr, rd, inm, busy, spv, rdv, res;
    logic [15:0] pc, sp, addr, spr, rpc, rsp_q;
    logic [7:0]  a, xl, h, cc, wd, rdat, ra, rxl, rh, rcc;
    logic [7:0]  fr [1:6];
    int          n_fail, n_tests;
    msf_top dut (.clk(clk), .reset(reset), .enter_monitor(em), .run_cmd(run),
        .read_stack_pointer_cmd(rsp), .host_wr(wr), .host_rd(rd), .host_addr(addr),
        .host_wdata(wd), .core_pc(pc), .core_a(a), .core_xl(xl), .core_h(h),
        .core_ccr(cc), .core_sp(sp), .in_monitor_q(inm), .busy_q(busy), .sp_read_q(spr),
        .sp_read_valid_q(spv), .host_rdata_q(rdat), .host_rdata_valid_q(rdv),
        .resume_q(res), .resume_pc_q(rpc), .resume_a_q(ra), .resume_xl_q(rxl),
        .resume_h_q(rh), .resume_ccr_q(rcc), .resume_sp_q(rsp_q));
    msf_host host (.clk(clk), .rdv(rdv), .run(run), .rsp(rsp), .wr(wr), .rd(rd),
        .addr(addr), .wdata(wd));
    task automatic complete_run();
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(input bit sel);
        bit ok;
        ok = 0;
        for (int i = 0; i < 12 && !ok; i++) begin
            @(negedge clk);
            ok = sel ? (res === 1'b1) : (inm === 1'b1);
        end
        check(16'(ok), 16'h0001);
        if (!ok) complete_run();
    endtask
    // Core state is scrambled right after entry to catch late sampling
    task automatic sc_save(input logic [15:0] s);
        bit ok;
        host.cmd(0);
        @(negedge clk);
        check(16'(spv), 16'h0000);
        host.cmd(1);
        @(negedge clk);
        check({14'h0000, busy, res}, 16'h0000);
        // Seeds follow s, the first follows h, so a later frame never matches stale restore values
        fr = '{h ^ 8'h3c, 8'hc5 ^ s[7:0], 8'h5a ^ s[7:0], 8'h96 ^ s[7:0],
               s[7:0] ^ 8'h21, ~s[7:0]};
        @(posedge clk);
        {h, cc, a, xl, pc} <= {fr[1], fr[2], fr[3], fr[4], fr[5], fr[6]};
        sp <= s;
        em <= 1'b1;
        @(posedge clk);
        em <= 1'b0;
        {pc, a, xl, h, cc} <= '1;
        wait_hi(0);
        host.cmd(0);
        @(negedge clk);
        check(16'(spv), 16'h0001);
        check(spr, s - 16'h0005);
        for (int k = 1; k <= 6; k++) begin
            host.get(s - 16'h0006 + 16'(k), ok);
            check({7'h00, ok, rdat}, {8'h01, fr[k]});
        end
    endtask
    task automatic sc_edit_run(input logic [15:0] s);
        for (int k = 1; k <= 6; k++) begin
            fr[k] = fr[k] ^ 8'(k * 17);
            host.put(s - 16'h0006 + 16'(k), fr[k]);
        end
        // A second entry while parked must not reload the stack pointer
        @(posedge clk);
        em <= 1'b1;
        sp <= ~s;
        @(posedge clk);
        em <= 1'b0;
        host.rd_run(s);
        @(negedge clk);
        check(16'(inm), 16'h0001);
        host.cmd(1);
        wait_hi(1);
        check({rh, rcc}, {fr[1], fr[2]});
        check({ra, rxl}, {fr[3], fr[4]});
        check(rpc, {fr[5], fr[6]});
        check(rsp_q, s);
    endtask
    initial begin
        clk = 0;
        forever #4 clk = ~clk;
    end
    initial begin
        {reset, em, pc, sp, a, xl, h, cc} = '0;
        reset = 1'b1;
        n_fail = 0;
        n_tests = 0;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        check(rsp_q, MSF_SP_RESET);
        sc_save(16'h00ff);
        sc_edit_run(16'h00ff);
        sc_save(16'h0002);
        sc_edit_run(16'h0002);
        complete_run();
    end
endmodule
`default_nettype wire
